// file: common/port_ctrl_pkg.sv
// Purpose: constants and carriers for the per-port control bank
// Assumes: 16-bit registers, one per aligned 32-bit Wishbone word
// Notes:   offsets are register indices; byte address is index times 4
package port_ctrl_pkg;
	localparam int          ADR_W     = 13;
	localparam int          PSEL_LSB  = 9;
	localparam logic [8:0]  OFS_CR1   = 9'h040;
	localparam logic [8:0]  OFS_CR2   = 9'h042;
	localparam logic [8:0]  OFS_CR3   = 9'h044;
	localparam logic [8:0]  OFS_CR4   = 9'h046;
	localparam logic [8:0]  OFS_INV1  = 9'h04A;
	localparam logic [8:0]  OFS_INV2  = 9'h04C;
	localparam logic [8:0]  OFS_ISR   = 9'h050;
	localparam logic [8:0]  OFS_SR    = 9'h052;
	localparam logic [8:0]  OFS_SRL   = 9'h054;
	localparam logic [8:0]  OFS_SRIE  = 9'h056;
	localparam logic [15:0] RST_CR1   = 16'h0006;
	localparam logic [15:0] RST_ZERO  = 16'h0000;
	localparam logic [15:0] MSK_CR1   = 16'h7EDF;
	localparam logic [15:0] MSK_CR2   = 16'hF738;
	localparam logic [15:0] MSK_CR3   = 16'h36FF;
	localparam logic [15:0] MSK_CR4   = 16'h07FF;
	localparam logic [15:0] MSK_INV1  = 16'h17FF;
	localparam logic [15:0] MSK_INV2  = 16'h16DE;
	localparam logic [15:0] MSK_SRIE  = 16'h0007;
	localparam int CR1_PAYLOAD_AIS_SELECT  = 12;
	localparam int CR1_LINE_AIS_SELECT  = 10;
	localparam int CR1_PATTERN_TESTER_ENABLE  = 9;
	localparam int CR1_MANUAL_ERROR_INSERT  = 7;
	localparam int CR1_ERROR_INSERT_MODE  = 6;
	localparam int CR1_MONITOR_UPDATE_MODE  = 4;
	localparam int CR1_PMU   = 3;
	localparam int CR1_PD    = 2;
	localparam int CR1_DATAPATH_SOFT_RESET = 1;
	localparam int CR1_RST   = 0;
	localparam int CR2_TX_LINE_OUTPUT_ENABLE  = 15;
	localparam int CR2_TTS   = 14;
	localparam int CR2_RX_MONITOR_PREAMP  = 13;
	localparam int CR2_TX_CABLE_BUILDOUT  = 12;
	localparam int CR2_LM    = 8;
	localparam int CR2_FM    = 3;
	localparam int CR3_RX_CLOCK_OUT_SELECT = 13;
	localparam int CR3_RSOF  = 12;
	localparam int CR3_TX_CLOCK_OUT_SELECT = 10;
	localparam int CR3_TSOF  = 9;
	localparam int CR3_PORT_8K_SOURCE_SELECT = 6;
	localparam int CR3_PORT_8K_REFERENCE_USE = 5;
	localparam int CR3_LOOP_TIMING_ENABLE = 4;
	localparam int CR3_RATE_ADAPTER_TX_CLOCK_CTRL = 3;
	localparam int ISR_PSR   = 9;
	localparam int CLK_NS    = 40;
	localparam int RST_MIN_NS = 100;
	localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [3:0] {
		SRC_TXCLK_IN  = 4'b0001,
		SRC_RX_LINE   = 4'b0010,
		SRC_RECOVERED = 4'b0100,
		SRC_RATE_ADPT = 4'b1000
	} tx_clk_src_t;

	// per-port control levels handed to the port's data path
	typedef struct packed {
		logic [2:0]  payload_ais_select;
		logic [1:0]  line_ais_select;
		logic        bert_en;
		logic        clock_run;
		logic        dp_reset;
		logic        port_reset;
		logic        rx_preamp;
		logic        tx_buildout;
		logic        liu_en;
		logic        ja_en;
		logic [2:0]  lm;
		logic [2:0]  fm;
		logic [15:0] cr4;
		logic [15:0] inv1;
		logic [15:0] inv2;
		tx_clk_src_t tx_clk_src;
		logic        err_insert;
		logic        pm_load;
	} port_ctrl_t;

	// per-port signals arriving from the data path
	typedef struct packed {
		logic [7:0] payload_ais_select_cond;
		logic [3:0] line_ais_select_cond;
		logic       dlb_active;
		logic       rx_payload;
		logic       bert_data;
		logic       tx_serial;
		logic       tx_pos;
		logic       tx_neg;
		logic       tx_lclk;
		logic       ais_pos;
		logic       ais_neg;
		logic       rx_gclk;
		logic       rx_clko;
		logic       rx_den;
		logic       rx_sof;
		logic       tx_gclk;
		logic       tx_clko;
		logic       tx_den;
		logic       tx_sof;
		logic       rx_8k;
		logic       tx_8k;
		logic       pm_done;
		logic       rlol;
		logic       tdm;
		logic [15:0] isr_src;
	} port_in_t;

	// per-port pin and data outputs
	typedef struct packed {
		logic rx_payload;
		logic tx_payload;
		logic tx_pos;
		logic tx_neg;
		logic tx_lclk;
		logic line_ais;
		logic drv_plus;
		logic drv_minus;
		logic drv_oe;
		logic rx_clk_pin;
		logic rx_sof_pin;
		logic tx_clk_pin;
		logic tx_sof_pin;
		logic port_8k;
		logic ref_8k;
	} port_out_t;
endpackage : port_ctrl_pkg

// file: tb/testbench.sv
// Purpose: self-checking bench for the per-port control bank
// Assumes: one-cycle Wishbone ack; port outputs one cycle behind inputs
// Notes:   only port 0 pins are exercised; copies checked via registers
`timescale 1ns/1ps
module testbench;
	import port_ctrl_pkg::*;

	logic                        clk_i;
	logic                        rst_i;
	logic                        glb_rst;
	logic                        cyc;
	logic                        stb;
	logic                        we;
	logic [ADR_W-1:0]            adr;
	logic [3:0]                  sel;
	logic [31:0]                 wdat;
	logic [31:0]                 dat_o;
	logic                        ack_o;
	logic                        g_ins;
	logic                        g_upd;
	logic                        g_8k;
	port_in_t   [3:0]            pin;
	port_ctrl_t [3:0]            ctrl;
	port_out_t  [3:0]            pout;
	int                          n_errors;
	int                          check_count;
	int                          n_ins;
	int                          n_ld;
	logic [15:0]                 rv;
	logic [8:0]                  ofs_tab [6];
	logic [15:0]                 msk_tab [6];

	per_port_common_control #(.NUM_PORTS(4)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .glb_rst_i(glb_rst), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
		.dat_o(dat_o), .ack_o(ack_o), .glb_insert_i(g_ins),
		.glb_update_i(g_upd), .glb_8k_i(g_8k), .pin_i(pin),
		.ctrl_o(ctrl), .pout_o(pout)
	);

	// 25 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// count one-cycle pulses; a stuck pulse shows as a big count
	always @(posedge clk_i) begin
		if (ctrl[0].err_insert === 1'b1) n_ins <= n_ins + 1;
		if (ctrl[0].pm_load === 1'b1) n_ld <= n_ld + 1;
	end

	task automatic end_of_test;
		if (n_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	// classic cycle: hold request until ack is sampled, then idle a cycle
	task automatic wb(input logic w, input logic [1:0] p,
			input logic [8:0] o, input logic [15:0] d);
		int n;
		n = 0;
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= {p, o, 2'b00};
		wdat <= {16'h0000, d};
		sel  <= 4'h3;
		// look at ack mid-cycle, where it has settled; the edge that
		// follows is the one at which the slave sees it taken
		do begin
			@(negedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20) n_errors++;
		rv = dat_o[15:0];
		@(posedge clk_i);
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic rd(input logic [1:0] p, input logic [8:0] o,
			input logic [15:0] exp);
		wb(1'b0, p, o, 16'h0000);
		chk(rv, exp);
	endtask : rd

	task automatic settle;
		repeat (3) @(posedge clk_i);
	endtask : settle

	// watchdog: the sequence needs well under a thousand cycles
	initial begin
		#(40 * 5000);
		n_errors++;
		end_of_test();
	end

	initial begin
		n_errors = 0; check_count = 0; n_ins = 0; n_ld = 0;
		rst_i = 1'b1; glb_rst = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
		adr = '0; sel = 4'h3; wdat = '0; g_ins = 1'b0; g_upd = 1'b0;
		g_8k = 1'b0; pin = '0;
		pin[0].rx_clko = 1'b1; pin[0].rx_sof = 1'b1; pin[0].tx_clko = 1'b1;
		pin[0].tx_sof = 1'b1; pin[0].tx_8k = 1'b1;
		ofs_tab = '{OFS_CR2, OFS_CR3, OFS_CR4, OFS_INV1, OFS_INV2, OFS_SRIE};
		msk_tab = '{MSK_CR2, MSK_CR3, MSK_CR4, MSK_INV1, MSK_INV2, MSK_SRIE};
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// reset values and reset-time levels
		rd(2'h0, OFS_CR1, RST_CR1);
		rd(2'h3, OFS_CR2, RST_ZERO);
		chk(ctrl[0].clock_run, 16'h0000);
		chk(ctrl[0].dp_reset, 16'h0001);
		chk(ctrl[0].liu_en, 16'h0000);
		// every port copy keeps its own value, reserved bits read zero
		for (int p = 0; p < 4; p++)
			for (int i = 0; i < 6; i++)
				wb(1'b1, p[1:0], ofs_tab[i], 16'hFFFF >> p);
		for (int p = 0; p < 4; p++)
			for (int i = 0; i < 6; i++)
				rd(p[1:0], ofs_tab[i], (16'hFFFF >> p) & msk_tab[i]);
		// unused places and a read-only register ignore writes
		wb(1'b1, 2'h0, 9'h048, 16'hFFFF);
		rd(2'h0, 9'h048, 16'h0000);
		wb(1'b1, 2'h2, 9'h058, 16'hFFFF);
		rd(2'h2, 9'h058, 16'h0000);
		wb(1'b1, 2'h0, OFS_ISR, 16'hFFFF);
		rd(2'h0, OFS_ISR, 16'h0000);
		// release power-down and data-path reset
		wb(1'b1, 2'h0, OFS_CR1, 16'h0000);
		chk(ctrl[0].clock_run, 16'h0001);
		chk(ctrl[0].dp_reset, 16'h0000);
		// payload and line AIS codes 5 and 2
		wb(1'b1, 2'h0, OFS_CR1, 16'h5800);
		pin[0].payload_ais_select_cond[5] <= 1'b1;
		pin[0].line_ais_select_cond[2] <= 1'b1;
		settle();
		chk(pout[0].rx_payload, 16'h0001);
		chk(pout[0].line_ais, 16'h0001);
		pin[0].payload_ais_select_cond[5] <= 1'b0;
		pin[0].line_ais_select_cond[2] <= 1'b0;
		settle();
		chk(pout[0].rx_payload, 16'h0000);
		chk(pout[0].line_ais, 16'h0000);
		// code zero: payload always, line only in diagnostic loopback
		wb(1'b1, 2'h0, OFS_CR1, 16'h0000);
		settle();
		chk(pout[0].rx_payload, 16'h0001);
		chk(pout[0].line_ais, 16'h0000);
		pin[0].dlb_active <= 1'b1;
		settle();
		chk(pout[0].line_ais, 16'h0001);
		pin[0].dlb_active <= 1'b0;
		// pattern tester replaces serial input
		pin[0].bert_data <= 1'b1;
		wb(1'b1, 2'h0, OFS_CR1, 16'h0200);
		settle();
		chk(pout[0].tx_payload, 16'h0001);
		wb(1'b1, 2'h0, OFS_CR1, 16'h0000);
		settle();
		chk(pout[0].tx_payload, 16'h0000);
		// error insert: local bit, then global source only
		wb(1'b1, 2'h0, OFS_CR1, 16'h0080);
		wb(1'b1, 2'h0, OFS_CR1, 16'h0040);
		wb(1'b1, 2'h0, OFS_CR1, 16'h00C0);
		g_ins <= 1'b1;
		settle();
		g_ins <= 1'b0;
		chk(16'(n_ins), 16'h0002);
		// monitor update handshake in port mode
		wb(1'b1, 2'h0, OFS_CR1, 16'h0008);
		pin[0].pm_done <= 1'b1;
		settle();
		chk(16'(n_ld), 16'h0001);
		rd(2'h0, OFS_SR, 16'h0001);
		rd(2'h0, OFS_ISR, 16'h0200);
		pin[0].pm_done <= 1'b0;
		wb(1'b1, 2'h0, OFS_CR1, 16'h0000);
		settle();
		rd(2'h0, OFS_SR, 16'h0000);
		wb(1'b1, 2'h0, OFS_SRL, 16'h0001);
		rd(2'h0, OFS_SRL, 16'h0000);
		// global update mode ignores the local request
		wb(1'b1, 2'h0, OFS_CR1, 16'h0010);
		wb(1'b1, 2'h0, OFS_CR1, 16'h0018);
		g_upd <= 1'b1;
		settle();
		g_upd <= 1'b0;
		chk(16'(n_ld), 16'h0002);
		wb(1'b1, 2'h0, OFS_CR1, 16'h0000);
		// line outputs, driver enable, pre-amp and build-out
		pin[0].tx_pos <= 1'b1;
		wb(1'b1, 2'h0, OFS_CR2, 16'h8100);
		settle();
		chk(pout[0].tx_pos, 16'h0001);
		chk(pout[0].drv_oe, 16'h0001);
		chk(pout[0].drv_plus, 16'h0001);
		wb(1'b1, 2'h0, OFS_CR2, 16'h7100);
		settle();
		chk(pout[0].tx_pos, 16'h0000);
		chk(pout[0].drv_oe, 16'h0000);
		chk(ctrl[0].rx_preamp, 16'h0001);
		chk(ctrl[0].tx_buildout, 16'h0001);
		wb(1'b1, 2'h0, OFS_CR2, 16'h1028);
		chk(ctrl[0].tx_buildout, 16'h0000);
		chk(ctrl[0].liu_en, 16'h0000);
		chk(ctrl[0].fm, 16'h0005);
		// output selects, 8 kHz sources and transmit clock source
		wb(1'b1, 2'h0, OFS_CR3, 16'h3678);
		settle();
		chk({pout[0].rx_clk_pin, pout[0].rx_sof_pin}, 16'h0003);
		chk({pout[0].tx_clk_pin, pout[0].tx_sof_pin}, 16'h0003);
		chk({pout[0].port_8k, pout[0].ref_8k}, 16'h0003);
		chk(ctrl[0].tx_clk_src, SRC_RX_LINE);
		wb(1'b1, 2'h0, OFS_CR3, 16'h0008);
		settle();
		chk({pout[0].rx_clk_pin, pout[0].tx_sof_pin}, 16'h0000);
		chk({pout[0].port_8k, pout[0].ref_8k}, 16'h0000);
		chk(ctrl[0].tx_clk_src, SRC_TXCLK_IN);
		wb(1'b1, 2'h0, OFS_CR3, 16'h0000);
		chk(ctrl[0].tx_clk_src, SRC_RATE_ADPT);
		// port reset bit defaults the rest of the port
		wb(1'b1, 2'h0, OFS_CR2, 16'h8100);
		wb(1'b1, 2'h0, OFS_CR1, 16'h0001);
		rd(2'h0, OFS_CR2, 16'h0000);
		rd(2'h0, OFS_CR1, 16'h0007);
		wb(1'b1, 2'h0, OFS_CR1, 16'h0000);
		// global reset returns every port to power-down
		glb_rst <= 1'b1;
		@(posedge clk_i);
		glb_rst <= 1'b0;
		@(posedge clk_i);
		rd(2'h1, OFS_CR1, RST_CR1);
		rd(2'h1, OFS_CR2, 16'h0000);
		end_of_test();
	end
endmodule : testbench

// file: verilog/per_port_common_control.sv
// Purpose: per-port common control bank, Wishbone classic slave
// Assumes: all port inputs synchronous to clk_i
// Notes:   one register copy per port, ports 0x200 indices apart
// Contract
// - payload AIS code forces all-ones on receive payload; code 0 always
// - line AIS code forces AIS onto transmit line; code 0 on loopback
// - pattern tester enable swaps tester data for serial input
// - rising manual insert bit fires an error insert pulse
// - insert mode picks local insert bit or global insert source
// - update mode picks local request or global update mechanism
// - rising update request loads monitor registers, resets counters
// - request held until done; lowering request clears done
// - power-down stops port clocks; resets to powered down
// - data-path reset holds data path; software holds it 100 ns
// - port reset bit defaults the port, ORed with other resets
// - transmit line enable low forces line clock and data low
// - tri-state floats drivers only while line interface is powered
// - monitor bit switches in the 20 dB receive pre-amplifier
// - build-out shapes for 225 feet, only in line interface mode
// - interface mode field; zero disables line unit and attenuator
// - clock output selects pick gapped clock or clock output
// - frame start selects pick data enable or frame start pulse
// - 8 kHz source select picks receive or transmit framer clock
// - 8 kHz use bit picks global or this port's reference
// - loop timing takes transmit clock from receive side while rate adapter control is set
// - rate adapter control picks adapter clocks or clock input
`timescale 1ns/1ps
module per_port_common_control #(
	parameter int NUM_PORTS = 4
) (
	input  wire logic                   clk_i,       // 25 MHz
	input  wire logic                   rst_i,       // sync, high
	input  wire logic                   glb_rst_i,   // global reset
	input  wire logic                   cyc_i,       // wb cycle
	input  wire logic                   stb_i,       // wb strobe
	input  wire logic                   we_i,        // wb write
	input  wire logic [port_ctrl_pkg::ADR_W-1:0] adr_i, // byte address
	input  wire logic [3:0]             sel_i,       // byte lanes
	input  wire logic [31:0]            dat_i,       // write data
	output logic      [31:0]            dat_o,       // read data
	output logic                        ack_o,       // wb ack
	input  wire logic                   glb_insert_i, // global insert
	input  wire logic                   glb_update_i, // global update
	input  wire logic                   glb_8k_i,    // global 8 kHz
	input  port_ctrl_pkg::port_in_t [NUM_PORTS-1:0]   pin_i, // per port
	output port_ctrl_pkg::port_ctrl_t [NUM_PORTS-1:0] ctrl_o, // levels
	output port_ctrl_pkg::port_out_t [NUM_PORTS-1:0]  pout_o  // pins
);
	import port_ctrl_pkg::*;

	logic [15:0] cr1_q  [NUM_PORTS];
	logic [15:0] cr2_q  [NUM_PORTS];
	logic [15:0] cr3_q  [NUM_PORTS];
	logic [15:0] cr4_q  [NUM_PORTS];
	logic [15:0] inv1_q [NUM_PORTS];
	logic [15:0] inv2_q [NUM_PORTS];
	logic [15:0] srl_q  [NUM_PORTS];
	logic [15:0] srie_q [NUM_PORTS];
	logic [15:0] sr_w   [NUM_PORTS];
	logic [15:0] isr_w  [NUM_PORTS];
	logic        ack_q;
	logic        hit_q;
	logic [31:0] dat_q;
	logic        wr_go;
	logic [15:0] wmask;
	logic [8:0]  ofs;
	logic [1:0]  psel;
	logic        pok;
	logic [15:0] rd_d;
	logic        hit_d;

	assign ofs  = adr_i[PSEL_LSB+1:2];
	assign psel = adr_i[PSEL_LSB+3:PSEL_LSB+2];
	assign pok  = (32'(psel) < NUM_PORTS);
	// write lands at the edge where the master sees ack
	assign wr_go = cyc_i & stb_i & we_i & ack_q;
	assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// read decode; unmapped and reserved bits read zero
	always_comb begin
		rd_d  = RST_ZERO;
		hit_d = 1'b1;
		if (!pok) begin
			hit_d = 1'b0;
		end else if (ofs == OFS_CR1) begin
			rd_d = cr1_q[psel];
		end else if (ofs == OFS_CR2) begin
			rd_d = cr2_q[psel];
		end else if (ofs == OFS_CR3) begin
			rd_d = cr3_q[psel];
		end else if (ofs == OFS_CR4) begin
			rd_d = cr4_q[psel];
		end else if (ofs == OFS_INV1) begin
			rd_d = inv1_q[psel];
		end else if (ofs == OFS_INV2) begin
			rd_d = inv2_q[psel];
		end else if (ofs == OFS_ISR) begin
			rd_d = isr_w[psel];
		end else if (ofs == OFS_SR) begin
			rd_d = sr_w[psel];
		end else if (ofs == OFS_SRL) begin
			rd_d = srl_q[psel];
		end else if (ofs == OFS_SRIE) begin
			rd_d = srie_q[psel];
		end else begin
			hit_d = 1'b0;
		end
	end

	// one wait state: ack and read data rise together
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			hit_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= cyc_i & stb_i & ~ack_q;
			hit_q <= hit_d;
			dat_q <= {16'h0000, rd_d};
		end
	end

	genvar p;
	generate
	for (p = 0; p < NUM_PORTS; p++) begin : g_port
		logic hard_rst;
		logic prst;
		logic wsel;
		logic liu_on;
		logic manual_error_insert_q;
		logic ginsq_q;
		logic pmu_q;
		logic gupd_q;
		logic done_q;
		logic req_lvl;
		logic [15:0] srprev_q;
		port_out_t   po_q;
		logic        ins_q;
		logic        load_q;
		logic        payload_ais_select_f;
		logic        line_ais_select_f;

		assign hard_rst = rst_i | glb_rst_i;
		assign prst     = hard_rst | cr1_q[p][CR1_RST];
		assign wsel     = wr_go & pok & (32'(psel) == p);
		assign liu_on   = (cr2_q[p][CR2_LM+:3] != 3'h0)
			& ~cr1_q[p][CR1_PD];

		// the reset bit survives its own port reset
		always_ff @(posedge clk_i) begin
			if (hard_rst) begin
				cr1_q[p][CR1_RST] <= RST_CR1[CR1_RST];
			end else if (wsel && ofs == OFS_CR1 && sel_i[0]) begin
				cr1_q[p][CR1_RST] <= dat_i[CR1_RST];
			end
		end

		// control registers; port reset restores defaults
		always_ff @(posedge clk_i) begin
			if (prst) begin
				cr1_q[p][15:1] <= RST_CR1[15:1];
				cr2_q[p]  <= RST_ZERO;
				cr3_q[p]  <= RST_ZERO;
				cr4_q[p]  <= RST_ZERO;
				inv1_q[p] <= RST_ZERO;
				inv2_q[p] <= RST_ZERO;
				srie_q[p] <= RST_ZERO;
			end else if (wsel) begin
				if (ofs == OFS_CR1) begin
					cr1_q[p][15:1] <= ((dat_i[15:1] & wmask[15:1])
						| (cr1_q[p][15:1] & ~wmask[15:1]))
						& MSK_CR1[15:1];
				end else if (ofs == OFS_CR2) begin
					cr2_q[p] <= ((dat_i[15:0] & wmask)
						| (cr2_q[p] & ~wmask)) & MSK_CR2;
				end else if (ofs == OFS_CR3) begin
					cr3_q[p] <= ((dat_i[15:0] & wmask)
						| (cr3_q[p] & ~wmask)) & MSK_CR3;
				end else if (ofs == OFS_CR4) begin
					cr4_q[p] <= ((dat_i[15:0] & wmask)
						| (cr4_q[p] & ~wmask)) & MSK_CR4;
				end else if (ofs == OFS_INV1) begin
					inv1_q[p] <= ((dat_i[15:0] & wmask)
						| (inv1_q[p] & ~wmask)) & MSK_INV1;
				end else if (ofs == OFS_INV2) begin
					inv2_q[p] <= ((dat_i[15:0] & wmask)
						| (inv2_q[p] & ~wmask)) & MSK_INV2;
				end else if (ofs == OFS_SRIE) begin
					srie_q[p] <= ((dat_i[15:0] & wmask)
						| (srie_q[p] & ~wmask)) & MSK_SRIE;
				end
			end
		end

		// live status and summary; summary bit from enabled latches
		assign sr_w[p] = {13'h0000, pin_i[p].tdm, pin_i[p].rlol, done_q};
		always_comb begin
			isr_w[p] = pin_i[p].isr_src & 16'h03F1;
			isr_w[p][ISR_PSR] = |(srl_q[p] & srie_q[p]);
		end

		// latched status: a new rise beats a same-cycle clear
		always_ff @(posedge clk_i) begin
			if (prst) begin
				srl_q[p]    <= RST_ZERO;
				srprev_q    <= RST_ZERO;
			end else begin
				srprev_q <= sr_w[p];
				srl_q[p] <= (srl_q[p] & ~((wsel && ofs == OFS_SRL)
					? (dat_i[15:0] & wmask) : RST_ZERO))
					| (sr_w[p] & ~srprev_q & MSK_SRIE);
			end
		end

		// edge detectors for insert and update triggers
		always_ff @(posedge clk_i) begin
			if (prst) begin
				manual_error_insert_q  <= 1'b0;
				ginsq_q <= 1'b0;
				pmu_q   <= 1'b0;
				gupd_q  <= 1'b0;
				ins_q   <= 1'b0;
				load_q  <= 1'b0;
			end else begin
				manual_error_insert_q  <= cr1_q[p][CR1_MANUAL_ERROR_INSERT];
				ginsq_q <= glb_insert_i;
				pmu_q   <= cr1_q[p][CR1_PMU];
				gupd_q  <= glb_update_i;
				ins_q   <= cr1_q[p][CR1_ERROR_INSERT_MODE]
					? (glb_insert_i & ~ginsq_q)
					: (cr1_q[p][CR1_MANUAL_ERROR_INSERT] & ~manual_error_insert_q);
				load_q  <= cr1_q[p][CR1_MONITOR_UPDATE_MODE]
					? (glb_update_i & ~gupd_q)
					: (cr1_q[p][CR1_PMU] & ~pmu_q);
			end
		end

		// done follows counters; dropping the request clears it
		assign req_lvl = cr1_q[p][CR1_MONITOR_UPDATE_MODE] ? glb_update_i
			: cr1_q[p][CR1_PMU];
		always_ff @(posedge clk_i) begin
			if (prst) begin
				done_q <= 1'b0;
			end else if (pin_i[p].pm_done && req_lvl) begin
				done_q <= 1'b1;
			end else if (!req_lvl) begin
				done_q <= 1'b0;
			end
		end

		// force conditions: code zero has a fixed meaning
		assign payload_ais_select_f = (cr1_q[p][CR1_PAYLOAD_AIS_SELECT+:3] == 3'h0) ? 1'b1
			: pin_i[p].payload_ais_select_cond[cr1_q[p][CR1_PAYLOAD_AIS_SELECT+:3]];
		assign line_ais_select_f = (cr1_q[p][CR1_LINE_AIS_SELECT+:2] == 2'h0)
			? pin_i[p].dlb_active
			: pin_i[p].line_ais_select_cond[cr1_q[p][CR1_LINE_AIS_SELECT+:2]];

		// registered pin outputs; all low while port held in reset
		always_ff @(posedge clk_i) begin
			if (prst) begin
				po_q <= '0;
			end else begin
				po_q.rx_payload <= payload_ais_select_f | pin_i[p].rx_payload;
				po_q.tx_payload <= cr1_q[p][CR1_PATTERN_TESTER_ENABLE]
					? pin_i[p].bert_data : pin_i[p].tx_serial;
				po_q.line_ais <= line_ais_select_f;
				po_q.tx_pos <= cr2_q[p][CR2_TX_LINE_OUTPUT_ENABLE] & (line_ais_select_f
					? pin_i[p].ais_pos : pin_i[p].tx_pos);
				po_q.tx_neg <= cr2_q[p][CR2_TX_LINE_OUTPUT_ENABLE] & (line_ais_select_f
					? pin_i[p].ais_neg : pin_i[p].tx_neg);
				po_q.tx_lclk <= cr2_q[p][CR2_TX_LINE_OUTPUT_ENABLE]
					& pin_i[p].tx_lclk;
				po_q.drv_plus <= line_ais_select_f ? pin_i[p].ais_pos
					: pin_i[p].tx_pos;
				po_q.drv_minus <= line_ais_select_f ? pin_i[p].ais_neg
					: pin_i[p].tx_neg;
				// a powered-down unit never drives
				po_q.drv_oe <= liu_on & ~cr2_q[p][CR2_TTS];
				po_q.rx_clk_pin <= cr3_q[p][CR3_RX_CLOCK_OUT_SELECT]
					? pin_i[p].rx_clko : pin_i[p].rx_gclk;
				po_q.tx_clk_pin <= cr3_q[p][CR3_TX_CLOCK_OUT_SELECT]
					? pin_i[p].tx_clko : pin_i[p].tx_gclk;
				po_q.rx_sof_pin <= cr3_q[p][CR3_RSOF]
					? pin_i[p].rx_sof : pin_i[p].rx_den;
				po_q.tx_sof_pin <= cr3_q[p][CR3_TSOF]
					? pin_i[p].tx_sof
					: pin_i[p].tx_den;
				po_q.port_8k <= cr3_q[p][CR3_PORT_8K_SOURCE_SELECT]
					? pin_i[p].tx_8k : pin_i[p].rx_8k;
				po_q.ref_8k <= cr3_q[p][CR3_PORT_8K_REFERENCE_USE]
					? (cr3_q[p][CR3_PORT_8K_SOURCE_SELECT] ? pin_i[p].tx_8k
					: pin_i[p].rx_8k) : glb_8k_i;
			end
		end
		assign pout_o[p] = po_q;

		// control levels to the port data path
		always_comb begin
			ctrl_o[p].payload_ais_select        = cr1_q[p][CR1_PAYLOAD_AIS_SELECT+:3];
			ctrl_o[p].line_ais_select        = cr1_q[p][CR1_LINE_AIS_SELECT+:2];
			ctrl_o[p].bert_en     = cr1_q[p][CR1_PATTERN_TESTER_ENABLE];
			ctrl_o[p].clock_run   = ~cr1_q[p][CR1_PD];
			ctrl_o[p].dp_reset    = cr1_q[p][CR1_DATAPATH_SOFT_RESET] | prst;
			ctrl_o[p].port_reset  = prst;
			ctrl_o[p].rx_preamp   = cr2_q[p][CR2_RX_MONITOR_PREAMP];
			// build-out only meaningful with the line unit on
			ctrl_o[p].tx_buildout = cr2_q[p][CR2_TX_CABLE_BUILDOUT] & liu_on;
			ctrl_o[p].liu_en      = liu_on;
			ctrl_o[p].ja_en       = liu_on;
			ctrl_o[p].lm          = cr2_q[p][CR2_LM+:3];
			ctrl_o[p].fm          = cr2_q[p][CR2_FM+:3];
			ctrl_o[p].cr4         = cr4_q[p];
			ctrl_o[p].inv1        = inv1_q[p];
			ctrl_o[p].inv2        = inv2_q[p];
			ctrl_o[p].err_insert  = ins_q;
			ctrl_o[p].pm_load     = load_q;
			if (!cr3_q[p][CR3_RATE_ADAPTER_TX_CLOCK_CTRL]) begin
				ctrl_o[p].tx_clk_src = SRC_RATE_ADPT;
			end else if (cr3_q[p][CR3_LOOP_TIMING_ENABLE]) begin
				ctrl_o[p].tx_clk_src = liu_on ? SRC_RECOVERED
					: SRC_RX_LINE;
			end else begin
				ctrl_o[p].tx_clk_src = SRC_TXCLK_IN;
			end
		end

		property p_payload_ais_select;
			@(posedge clk_i) disable iff (prst)
			cr1_q[p][CR1_PAYLOAD_AIS_SELECT+:3] == 3'h0 |=> po_q.rx_payload;
		endproperty
		a_payload_ais_select: assert property (p_payload_ais_select)
			else $error("payload ais not forced");
		property p_bert;
			@(posedge clk_i) disable iff (prst)
			cr1_q[p][CR1_PATTERN_TESTER_ENABLE] |=>
				po_q.tx_payload == $past(pin_i[p].bert_data);
		endproperty
		a_bert: assert property (p_bert)
			else $error("tester data not on payload");
		property p_ins;
			@(posedge clk_i) disable iff (prst)
			!cr1_q[p][CR1_ERROR_INSERT_MODE] && $rose(cr1_q[p][CR1_MANUAL_ERROR_INSERT]) |=>
				ins_q ##1 !ins_q;
		endproperty
		a_ins: assert property (p_ins)
			else $error("insert pulse missing");
		property p_gins;
			@(posedge clk_i) disable iff (prst)
			cr1_q[p][CR1_ERROR_INSERT_MODE] && $past(cr1_q[p][CR1_ERROR_INSERT_MODE])
				&& ins_q |-> $past(glb_insert_i) && !$past(ginsq_q);
		endproperty
		a_gins: assert property (p_gins)
			else $error("insert pulse without global edge");
		property p_load;
			@(posedge clk_i) disable iff (prst)
			!cr1_q[p][CR1_MONITOR_UPDATE_MODE] && $rose(cr1_q[p][CR1_PMU]) |=> load_q;
		endproperty
		a_load: assert property (p_load)
			else $error("monitor load missing");
		property p_done;
			@(posedge clk_i) disable iff (prst)
			done_q && !req_lvl |=> !done_q;
		endproperty
		a_done: assert property (p_done)
			else $error("done not cleared on request low");
		property p_pd;
			@(posedge clk_i) disable iff (rst_i)
			cr1_q[p][CR1_PD] |-> !ctrl_o[p].clock_run ##1 !po_q.drv_oe;
		endproperty
		a_pd: assert property (p_pd)
			else $error("port running while powered down");
		property p_tx_line_output_enable;
			@(posedge clk_i) disable iff (prst)
			!cr2_q[p][CR2_TX_LINE_OUTPUT_ENABLE] |=> !po_q.tx_pos && !po_q.tx_neg
				&& !po_q.tx_lclk;
		endproperty
		a_tx_line_output_enable: assert property (p_tx_line_output_enable)
			else $error("line outputs not low when disabled");
		property p_tts;
			@(posedge clk_i) disable iff (prst)
			cr2_q[p][CR2_TTS] |=> !po_q.drv_oe;
		endproperty
		a_tts: assert property (p_tts)
			else $error("drivers on while tri-stated");
		property p_prst;
			@(posedge clk_i) disable iff (hard_rst)
			cr1_q[p][CR1_RST] |=> cr2_q[p] == RST_ZERO
				&& cr1_q[p][CR1_DATAPATH_SOFT_RESET] && cr1_q[p][CR1_PD];
		endproperty
		a_prst: assert property (p_prst)
			else $error("port reset left state");
	end
	endgenerate

	property p_unmap;
		@(posedge clk_i) disable iff (rst_i)
		ack_q && !hit_q |-> dat_q == 32'h0000_0000;
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");
endmodule : per_port_common_control
